// >>> tape_sense_status.sv
// extended sense status of the tape drive: unit flags, counters, pending sense
`timescale 1ns/1ps
module tape_sense_status #(
  parameter int NUM_INIT = 8,
  parameter int ID_W = 3,
  parameter int POS_W = 24
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic bus_reset_evt,
  input wire logic bus_dev_reset_evt,
  input wire logic bus_parity_evt,
  input wire logic buffer_parity_evt,
  input wire logic write_mode,
  input wire logic perm_write_err_evt,
  input wire logic uncorr_read_err_evt,
  input wire logic tracking_fail_evt,
  input wire logic cartridge_present,
  input wire logic at_logical_start,
  input wire logic at_physical_end,
  input wire logic write_protected,
  input wire logic old_format,
  input wire logic space_mark_err_evt,
  input wire logic [31:0] space_requested,
  input wire logic [31:0] space_processed,
  input wire logic mark_write_err_evt,
  input wire logic underrun_evt,
  input wire logic rewrite_limit_evt,
  input wire logic servo_fault_evt,
  input wire logic formatter_fault_evt,
  input wire logic reverse_retry_evt,
  input wire logic tape_loaded_evt,
  input wire logic rewind_evt,
  input wire logic cleaned_evt,
  input wire logic needs_clean_evt,
  input wire logic splice_blank_evt,
  input wire logic splice_overrun_evt,
  input wire logic [POS_W-1:0] logical_end_position,
  input wire logic [POS_W-1:0] physical_position,
  input wire logic tracking_retry_evt,
  input wire logic access_retry_evt,
  input wire logic param_err_evt,
  input wire logic [7:0] param_err_index,
  input wire logic cmd_valid,
  input wire logic [ID_W-1:0] cmd_init_id,
  input wire logic [7:0] cmd_opcode,
  input wire logic counter_clear_bit,
  input wire logic [7:0] cmd_alloc_len,
  input wire logic chk_valid,
  input wire logic [ID_W-1:0] chk_init_id,
  input wire logic [3:0] chk_sense_key,
  input wire logic [ID_W-1:0] rd_init_id,
  input wire logic [4:0] rd_addr,
  output logic [7:0] rd_data,
  output logic [NUM_INIT-1:0] pending_vec
);
  import sense_pkg::*;

  // hardware sets, clearing source clears; the set always wins
  function automatic logic [5:0] sticky(input logic [5:0] cur, input logic [5:0] set,
                                        input logic [5:0] clr);
    sticky = set | (cur & ~clr);
  endfunction

  logic dev_reset;
  logic sense_taken;
  logic keeps_sense;
  logic dir_change;
  logic cnt_clr;
  logic access_wrap;
  logic [7:0] track_cnt;
  logic [7:0] access_cnt;
  logic mode_prev_r;
  logic [5:0] flags_a_r;
  logic [5:0] flags_a_nxt;
  logic [5:0] flags_b_r;
  logic [5:0] flags_b_nxt;
  logic rrr_r;
  logic cleaning_done_flag_r;
  logic cln_r;
  logic [1:0] splice_r;
  logic [POS_W-1:0] remain_r;
  logic lat_key_v_r;
  logic [3:0] lat_key_r;
  logic [7:0] lat_fsc_r;
  logic lat_valid_r;
  logic [31:0] lat_info_r;
  logic [NUM_INIT-1:0] pend_r;
  logic [NUM_INIT-1:0] valid_r;
  logic [3:0] key_r [NUM_INIT];
  logic [7:0] fsc_r [NUM_INIT];
  logic [31:0] info_r [NUM_INIT];
  logic [7:0] byte_a;
  logic [7:0] byte_b;
  logic [7:0] byte_c;
  logic [7:0] rd_data_nxt;
  logic [7:0] rd_data_r;

  // bus resets count as device resets for flags and counters
  assign dev_reset = bus_reset_evt || bus_dev_reset_evt;
  assign sense_taken = cmd_valid && (cmd_opcode == OP_REQUEST_SENSE);
  assign keeps_sense = (cmd_opcode == OP_REQUEST_SENSE) || (cmd_opcode == OP_INQUIRY);

  // direction is watched from the previous cycle's mode
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode_prev_r <= 1'b0;
    end else begin
      mode_prev_r <= write_mode;
    end
  end
  assign dir_change = write_mode != mode_prev_r;

  // counter clear sources
  // a short allocation leaves the counters alone, so nothing is lost unseen
  assign cnt_clr = dev_reset || tape_loaded_evt || rewind_evt || dir_change ||
                   (sense_taken && counter_clear_bit && (cmd_alloc_len >= FULL_SENSE_LEN));

  retry_counter #(.WIDTH(8)) u_track_cnt (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clr(cnt_clr),
    .inc(tracking_retry_evt),
    .count(track_cnt),
    .wrapped()
  );

  retry_counter #(.WIDTH(8)) u_access_cnt (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clr(cnt_clr),
    .inc(access_retry_evt),
    .count(access_cnt),
    .wrapped(access_wrap)
  );

  // byte 19 sticky events; reported status clears them
  always_comb begin
    flags_a_nxt = '0;
    flags_a_nxt[F19_PWR] = dev_reset;
    // parity errors on bus and in buffer
    flags_a_nxt[F19_BPE] = bus_parity_evt;
    flags_a_nxt[F19_BUF] = buffer_parity_evt;
    flags_a_nxt[F19_REC] = (write_mode && perm_write_err_evt) ||
                           (!write_mode && uncorr_read_err_evt);
    flags_a_nxt[F19_OVF] = access_wrap;
    flags_a_nxt[F19_TRK] = tracking_fail_evt;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flags_a_r <= FLAGS_A_RESET;
    end else begin
      flags_a_r <= sticky(flags_a_r, flags_a_nxt, {6{sense_taken}});
    end
  end

  // byte 20 sticky events
  always_comb begin
    flags_b_nxt = '0;
    flags_b_nxt[F20_SPACE] = space_mark_err_evt && old_format;
    flags_b_nxt[F20_MARK] = mark_write_err_evt;
    flags_b_nxt[F20_UNDER] = underrun_evt;
    flags_b_nxt[F20_REWR] = rewrite_limit_evt;
    flags_b_nxt[F20_SERVO] = servo_fault_evt;
    flags_b_nxt[F20_FMT] = formatter_fault_evt || underrun_evt;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flags_b_r <= FLAGS_B_RESET;
    end else begin
      flags_b_r <= sticky(flags_b_r, flags_b_nxt, {6{sense_taken}});
    end
  end

  // reverse retries survive until a new tape loads
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rrr_r <= 1'b0;
    end else begin
      rrr_r <= reverse_retry_evt || (rrr_r && !tape_loaded_evt);
    end
  end

  // cleaning done lasts until the next sense request
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cleaning_done_flag_r <= 1'b0;
    end else begin
      cleaning_done_flag_r <= cleaned_evt || (cleaning_done_flag_r && !sense_taken);
    end
  end

  // clean request only drops on a good cleaning cycle
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cln_r <= 1'b0;
    end else begin
      cln_r <= needs_clean_evt || (cln_r && !cleaned_evt);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      splice_r <= 2'b00;
    end else begin
      splice_r <= {splice_blank_evt, splice_overrun_evt} | (splice_r & {2{!sense_taken}});
    end
  end

  // two's complement difference goes negative past the end
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      remain_r <= '0;
    end else if (!cartridge_present) begin
      remain_r <= '0;
    end else begin
      remain_r <= logical_end_position - physical_position;
    end
  end

  // bad select byte latches key five and one-based index
  // the latch waits for the check condition that hands it to an initiator
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lat_key_v_r <= 1'b0;
      lat_key_r <= KEY_NONE;
      lat_fsc_r <= COUNT_RESET;
    end else if (param_err_evt) begin
      lat_key_v_r <= 1'b1;
      lat_key_r <= KEY_ILLEGAL;
      lat_fsc_r <= param_err_index + SYMPTOM_FIRST;
    end else if (splice_blank_evt || splice_overrun_evt) begin
      lat_key_v_r <= 1'b1;
      lat_key_r <= KEY_HARDWARE;
    end else if (rewrite_limit_evt) begin
      lat_key_v_r <= 1'b1;
      lat_key_r <= KEY_MEDIUM;
    end else if (chk_valid || dev_reset) begin
      lat_key_v_r <= 1'b0;
      lat_fsc_r <= COUNT_RESET;
    end
  end

  // space failure on an old-format tape fills valid and requested minus processed
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lat_valid_r <= 1'b0;
      lat_info_r <= '0;
    end else if (space_mark_err_evt && old_format) begin
      lat_valid_r <= 1'b1;
      lat_info_r <= space_requested - space_processed;
    end else if (chk_valid || dev_reset) begin
      lat_valid_r <= 1'b0;
    end
  end

  // one sense slot per initiator, indexed by its id
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pend_r <= '0;
      valid_r <= '0;
      for (int i = 0; i < NUM_INIT; i++) begin
        key_r[i] <= KEY_NONE;
        fsc_r[i] <= COUNT_RESET;
        info_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_INIT; i++) begin
        // any bus or device reset drops every slot that gets no check condition in the same cycle
        if (dev_reset) begin
          pend_r[i] <= 1'b0;
          valid_r[i] <= 1'b0;
        // only other commands from the same id discard
        end else if (cmd_valid && !keeps_sense && (cmd_init_id == ID_W'(i))) begin
          pend_r[i] <= 1'b0;
          valid_r[i] <= 1'b0;
        end
        // a new check condition wins over a discard in the same cycle
        if (chk_valid && (chk_init_id == ID_W'(i))) begin
          pend_r[i] <= 1'b1;
          key_r[i] <= lat_key_v_r ? lat_key_r : chk_sense_key;
          fsc_r[i] <= lat_fsc_r;
          valid_r[i] <= lat_valid_r;
          info_r[i] <= lat_info_r;
        end
      end
    end
  end

  // live levels join sticky bits; reserved positions are zero
  // no cartridge and logical start follow the drive directly
  assign byte_a = {flags_a_r, !cartridge_present, at_logical_start};
  // write protect is a live level
  assign byte_b = {1'b0, flags_b_r[F20_SPACE], write_protected, flags_b_r[F20_MARK:0]};
  // physical end is a live level
  assign byte_c = {2'b00, rrr_r, cleaning_done_flag_r, cln_r, at_physical_end, splice_r};

  // sense byte read for the chosen initiator, one cycle of latency
  always_comb begin
    rd_data_nxt = 8'h00;
    unique case (rd_addr)
      // valid bit qualifies the information bytes
      BYTE_VALID: rd_data_nxt = {valid_r[rd_init_id], RESPONSE_CODE};
      BYTE_KEY: rd_data_nxt = {4'h0, key_r[rd_init_id]};
      BYTE_INFO_0: rd_data_nxt = info_r[rd_init_id][31:24];
      5'h04: rd_data_nxt = info_r[rd_init_id][23:16];
      5'h05: rd_data_nxt = info_r[rd_init_id][15:8];
      BYTE_INFO_3: rd_data_nxt = info_r[rd_init_id][7:0];
      BYTE_ADD_LEN: rd_data_nxt = ADD_SENSE_LEN;
      BYTE_FLAGS_A: rd_data_nxt = byte_a;
      BYTE_FLAGS_B: rd_data_nxt = byte_b;
      BYTE_FLAGS_C: rd_data_nxt = byte_c;
      BYTE_REMAIN_HI: rd_data_nxt = remain_r[23:16];
      BYTE_REMAIN_MID: rd_data_nxt = remain_r[15:8];
      BYTE_REMAIN_LO: rd_data_nxt = remain_r[7:0];
      BYTE_TRACK_CNT: rd_data_nxt = track_cnt;
      BYTE_ACCESS_CNT: rd_data_nxt = access_cnt;
      BYTE_SYMPTOM: rd_data_nxt = fsc_r[rd_init_id];
      default: rd_data_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rd_data_r <= 8'h00;
    end else begin
      rd_data_r <= rd_data_nxt;
    end
  end

  assign rd_data = rd_data_r;
  assign pending_vec = pend_r;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_reserved_zero: assert property (rd_addr == BYTE_FLAGS_C |=>
                                      rd_data[7:6] == 2'b00)
    else $error("reserved sense bits read nonzero");
  chk_power_flag: assert property ($rose(rstn) |-> flags_a_r[F19_PWR])
    else $error("power flag not set after reset");
  chk_parity_set: assert property (bus_parity_evt |=> flags_a_r[F19_BPE])
    else $error("bus parity flag missed");
  chk_overflow_set: assert property (access_wrap |=>
                                     flags_a_r[F19_OVF] && access_cnt == 8'h00)
    else $error("overflow flag or wrap wrong");
  chk_underrun_pair: assert property (underrun_evt |=>
                                      flags_b_r[F20_UNDER] && flags_b_r[F20_FMT])
    else $error("underrun did not set both flags");
  chk_clean_done: assert property (sense_taken && !cleaned_evt |=> !cleaning_done_flag_r)
    else $error("cleaning done survived sense request");
  chk_clean_hold: assert property (cln_r && !cleaned_evt |=> cln_r)
    else $error("clean request dropped early");
  chk_remain_zero: assert property (!cartridge_present |=> remain_r == '0)
    else $error("remaining tape nonzero without cartridge");
  chk_count_clear: assert property (cnt_clr && !tracking_retry_evt |=>
                                    track_cnt == 8'h00)
    else $error("tracking counter not cleared");
  chk_symptom_pos: assert property (param_err_evt ##1 chk_valid |=>
                                    fsc_r[$past(chk_init_id)] == $past(param_err_index, 2) + 8'h01)
    else $error("fault symptom position wrong");
  chk_pending_keep: assert property (pend_r[0] && !dev_reset &&
                                     !(cmd_valid && !keeps_sense && cmd_init_id == '0) |=> pend_r[0])
    else $error("pending sense lost early");
  chk_reset_drop: assert property (dev_reset && !chk_valid |=> pend_r == '0)
    else $error("pending sense kept across reset");

  cov_counter_clear: cover property (sense_taken && counter_clear_bit && access_cnt != 8'h00);
  cov_wrap: cover property (access_wrap);
  cov_param_report: cover property (param_err_evt ##[1:4] chk_valid);
  cov_two_pending: cover property ($countones(pend_r) > 1);
endmodule

// >>> sense_pkg.sv
// constants for the extended sense status block: byte map, flag bits, codes
package sense_pkg;
  // sense byte positions, first byte is 0
  localparam logic [4:0] BYTE_VALID = 5'h00;
  localparam logic [4:0] BYTE_KEY = 5'h02;
  localparam logic [4:0] BYTE_INFO_0 = 5'h03;
  localparam logic [4:0] BYTE_INFO_3 = 5'h06;
  localparam logic [4:0] BYTE_ADD_LEN = 5'h07;
  localparam logic [4:0] BYTE_FLAGS_A = 5'h13;
  localparam logic [4:0] BYTE_FLAGS_B = 5'h14;
  localparam logic [4:0] BYTE_FLAGS_C = 5'h15;
  localparam logic [4:0] BYTE_REMAIN_HI = 5'h17;
  localparam logic [4:0] BYTE_REMAIN_MID = 5'h18;
  localparam logic [4:0] BYTE_REMAIN_LO = 5'h19;
  localparam logic [4:0] BYTE_TRACK_CNT = 5'h1a;
  localparam logic [4:0] BYTE_ACCESS_CNT = 5'h1b;
  localparam logic [4:0] BYTE_SYMPTOM = 5'h1c;
  // fixed sense contents
  localparam logic [6:0] RESPONSE_CODE = 7'h70;
  localparam logic [7:0] ADD_SENSE_LEN = 8'h15;
  localparam logic [7:0] FULL_SENSE_LEN = 8'h1d;
  // command opcodes seen by the block
  localparam logic [7:0] OP_REQUEST_SENSE = 8'h03;
  localparam logic [7:0] OP_INQUIRY = 8'h12;
  // sense keys raised by the block itself
  localparam logic [3:0] KEY_NONE = 4'h0;
  localparam logic [3:0] KEY_MEDIUM = 4'h3;
  localparam logic [3:0] KEY_HARDWARE = 4'h4;
  localparam logic [3:0] KEY_ILLEGAL = 4'h5;
  // sticky flag positions inside the six-bit groups of bytes 19 and 20
  localparam int F19_PWR = 5;
  localparam int F19_BPE = 4;
  localparam int F19_BUF = 3;
  localparam int F19_REC = 2;
  localparam int F19_OVF = 1;
  localparam int F19_TRK = 0;
  localparam int F20_SPACE = 5;
  localparam int F20_MARK = 4;
  localparam int F20_UNDER = 3;
  localparam int F20_REWR = 2;
  localparam int F20_SERVO = 1;
  localparam int F20_FMT = 0;
  // values after reset
  localparam logic [5:0] FLAGS_A_RESET = 6'h20;
  localparam logic [5:0] FLAGS_B_RESET = 6'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] SYMPTOM_FIRST = 8'h01;
endpackage

// >>> retry_counter.sv
// saturating-free retry counter with clear, increment and wrap pulse
`timescale 1ns/1ps
module retry_counter #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clr,
  input wire logic inc,
  output logic [WIDTH-1:0] count,
  output logic wrapped
);
  import sense_pkg::*;

  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] count_nxt;

  // a clear in the same cycle as an increment keeps that increment
  always_comb begin
    if (clr) begin
      count_nxt = inc ? WIDTH'(1) : '0;
    end else begin
      count_nxt = count_r + WIDTH'(inc);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;
  // wrap only counts when the step really rolls over to zero
  assign wrapped = inc && !clr && (count_r == {WIDTH{1'b1}});

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  chk_wrap_zero: assert property (wrapped |=> count_r == '0)
    else $error("counter did not wrap to zero");
  chk_inc_step: assert property (inc && !clr && !wrapped |=>
                                 count_r == $past(count_r) + 1'b1)
    else $error("counter missed an increment");
endmodule

// >>> initiator_model.sv
// initiator-side model: issues commands and reads back sense bytes
`timescale 1ns/1ps
module initiator_model (
  input wire logic sys_clk,
  output logic cmd_valid,
  output logic [2:0] cmd_init_id,
  output logic [7:0] cmd_opcode,
  output logic counter_clear_bit,
  output logic [7:0] cmd_alloc_len,
  output logic [2:0] rd_init_id,
  output logic [4:0] rd_addr,
  input wire logic [7:0] rd_data
);
  // idle values at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_init_id = 3'h0;
    cmd_opcode = 8'h00;
    counter_clear_bit = 1'b0;
    cmd_alloc_len = 8'h00;
    rd_init_id = 3'h0;
    rd_addr = 5'h00;
  end
  // one-cycle command; opcode and length are scrambled after release so stale values never help
  // clear request only honoured with a full-length read
  task automatic send_cmd(input logic [2:0] id, input logic [7:0] op, input logic clr,
                          input logic [7:0] len);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_init_id <= id;
    cmd_opcode <= op;
    counter_clear_bit <= clr;
    cmd_alloc_len <= len;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_opcode <= ~op;
    cmd_alloc_len <= ~len;
  endtask
  // registered read: address taken at one edge, data settled just after it
  task automatic read_byte(input logic [2:0] id, input logic [4:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    rd_init_id <= id;
    rd_addr <= a;
    @(posedge sys_clk);
    #1;
    d = rd_data;
  endtask
endmodule

// >>> tape_sense_status_bench.sv
// self-checking bench for the extended sense status block
`timescale 1ns/1ps
module tape_sense_status_bench;
  import sense_pkg::*;
  logic sys_clk, rstn;
  // event pulses: 0 bus rst,1 dev rst,2 bus par,3 buf par,4 perm wr,5 uncorr rd,6 trk fail,
  // 7 space,8 mark,9 underrun,10 rewrite,11 servo,12 fmt,13 rev,14 load,15 rewind,
  // 16 cleaned,17 needs clean,18 spl blank,19 spl over,20 trk retry,21 acc retry,22 param,23 chk
  logic [23:0] ev;
  // levels: 0 write mode,1 cartridge,2 logical start,3 physical end,4 protect,5 old format
  logic [5:0] lv;
  logic [31:0] sp_req, sp_proc;
  logic [23:0] lep, pos;
  logic [7:0] perr_idx, cmd_opcode, cmd_alloc_len, rd_data, pending_vec;
  logic [2:0] chk_id, cmd_init_id, rd_init_id;
  logic [3:0] chk_key;
  logic [4:0] rd_addr;
  logic cmd_valid, counter_clear_bit;
  int n_fail, check_count;
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  tape_sense_status u_dut (.sys_clk(sys_clk), .rstn(rstn), .bus_reset_evt(ev[0]),
    .bus_dev_reset_evt(ev[1]), .bus_parity_evt(ev[2]), .buffer_parity_evt(ev[3]),
    .write_mode(lv[0]), .perm_write_err_evt(ev[4]), .uncorr_read_err_evt(ev[5]),
    .tracking_fail_evt(ev[6]), .cartridge_present(lv[1]), .at_logical_start(lv[2]),
    .at_physical_end(lv[3]), .write_protected(lv[4]), .old_format(lv[5]),
    .space_mark_err_evt(ev[7]), .space_requested(sp_req), .space_processed(sp_proc),
    .mark_write_err_evt(ev[8]), .underrun_evt(ev[9]), .rewrite_limit_evt(ev[10]),
    .servo_fault_evt(ev[11]), .formatter_fault_evt(ev[12]), .reverse_retry_evt(ev[13]),
    .tape_loaded_evt(ev[14]), .rewind_evt(ev[15]), .cleaned_evt(ev[16]),
    .needs_clean_evt(ev[17]), .splice_blank_evt(ev[18]), .splice_overrun_evt(ev[19]),
    .logical_end_position(lep), .physical_position(pos), .tracking_retry_evt(ev[20]),
    .access_retry_evt(ev[21]), .param_err_evt(ev[22]), .param_err_index(perr_idx),
    .cmd_valid(cmd_valid), .cmd_init_id(cmd_init_id), .cmd_opcode(cmd_opcode),
    .counter_clear_bit(counter_clear_bit), .cmd_alloc_len(cmd_alloc_len),
    .chk_valid(ev[23]), .chk_init_id(chk_id), .chk_sense_key(chk_key),
    .rd_init_id(rd_init_id), .rd_addr(rd_addr), .rd_data(rd_data),
    .pending_vec(pending_vec));
  initiator_model u_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
    .cmd_init_id(cmd_init_id), .cmd_opcode(cmd_opcode),
    .counter_clear_bit(counter_clear_bit), .cmd_alloc_len(cmd_alloc_len),
    .rd_init_id(rd_init_id), .rd_addr(rd_addr), .rd_data(rd_data));
  // one-cycle pulse on the selected event lines
  task automatic fire(input logic [23:0] m);
    @(posedge sys_clk);
    ev <= m;
    @(posedge sys_clk);
    ev <= '0;
  endtask
  task automatic set_lv(input logic [5:0] v);
    @(posedge sys_clk);
    lv <= v;
  endtask
  task automatic raise_check(input logic [2:0] id, input logic [3:0] k);
    @(posedge sys_clk);
    chk_id <= id;
    chk_key <= k;
    ev <= 24'h800000;
    @(posedge sys_clk);
    ev <= '0;
  endtask
  task automatic rs(input logic c, input logic [7:0] n);
    u_host.send_cmd(3'h0, OP_REQUEST_SENSE, c, n);
  endtask
  task automatic want(input logic [2:0] id, input logic [4:0] a, input logic [7:0] e);
    logic [7:0] d;
    u_host.read_byte(id, a, d);
    check_count++;
    if (d !== e) begin
      n_fail++;
      $display("BAD %0t byte %0d got %h want %h", $time, a, d, e);
    end
  endtask
  task automatic want_pend(input logic [7:0] e);
    @(posedge sys_clk);
    #1;
    check_count++;
    if (pending_vec !== e) begin
      n_fail++;
      $display("BAD %0t pending got %h want %h", $time, pending_vec, e);
    end
  endtask
  // fixed bytes, power flag and a reserved byte straight after reset
  task automatic t_reset();
    want(3'h0, 5'h13, 8'h81);
    want(3'h0, 5'h00, 8'h70);
    want(3'h0, 5'h07, 8'h15);
    want(3'h0, 5'h16, 8'h00);
    want(3'h0, 5'h1b, 8'h00);
  endtask
  // byte 19: read error ignored in write mode, sticky flags, live levels
  task automatic t_flags19();
    fire(24'h000020);
    rs(1'b0, 8'h1d);
    want(3'h0, 5'h13, 8'h01);
    fire(24'h000054);
    fire(24'h000008);
    want(3'h0, 5'h13, 8'h75);
    set_lv(6'h01);
    want(3'h0, 5'h13, 8'h76);
    rs(1'b0, 8'h1d);
    want(3'h0, 5'h13, 8'h02);
    set_lv(6'h03);
  endtask
  // byte 20, space mark info and automatic keys
  task automatic t_flags20();
    fire(24'h000080);
    want(3'h0, 5'h14, 8'h00);
    set_lv(6'h23);
    fire(24'h000080);
    want(3'h0, 5'h14, 8'h40);
    raise_check(3'h5, 4'h8);
    want(3'h5, 5'h00, 8'hf0);
    want(3'h5, 5'h02, 8'h08);
    want(3'h5, 5'h03, 8'h00);
    want(3'h5, 5'h06, 8'h03);
    set_lv(6'h13);
    fire(24'h000f00);
    want(3'h0, 5'h14, 8'h7f);
    // slot 0 gets the latched medium key and a clear valid bit
    raise_check(3'h0, 4'h0);
    want(3'h0, 5'h02, 8'h03);
    want(3'h0, 5'h00, 8'h70);
    rs(1'b0, 8'h1d);
    want(3'h0, 5'h14, 8'h20);
    fire(24'h001000);
    want(3'h0, 5'h14, 8'h21);
    rs(1'b0, 8'h1d);
    set_lv(6'h0b);
  endtask
  // byte 21 set and clear conditions
  task automatic t_flags21();
    fire(24'h0e2000);
    want(3'h0, 5'h15, 8'h2f);
    raise_check(3'h4, 4'h0);
    want(3'h4, 5'h02, 8'h04);
    fire(24'h010000);
    want(3'h0, 5'h15, 8'h37);
    rs(1'b0, 8'h1d);
    want(3'h0, 5'h15, 8'h24);
    fire(24'h004000);
    want(3'h0, 5'h15, 8'h04);
    set_lv(6'h03);
  endtask
  // remaining tape past the end, then with no cartridge
  task automatic t_remain();
    want(3'h0, 5'h17, 8'hff);
    want(3'h0, 5'h19, 8'h80);
    set_lv(6'h01);
    want(3'h0, 5'h19, 8'h00);
    set_lv(6'h03);
  endtask
  // counters: wrap, overflow flag, sense, direction and rewind clear paths
  task automatic t_counters();
    repeat (3) fire(24'h100000);
    want(3'h0, 5'h1a, 8'h03);
    @(posedge sys_clk);
    ev <= 24'h200000;
    repeat (256) @(posedge sys_clk);
    ev <= '0;
    want(3'h0, 5'h1b, 8'h00);
    want(3'h0, 5'h13, 8'h08);
    repeat (5) fire(24'h200000);
    rs(1'b1, 8'h1c);
    want(3'h0, 5'h1b, 8'h05);
    rs(1'b1, 8'h1d);
    want(3'h0, 5'h1a, 8'h00);
    fire(24'h200000);
    set_lv(6'h02);
    want(3'h0, 5'h1b, 8'h00);
    fire(24'h300000);
    fire(24'h008000);
    want(3'h0, 5'h1a, 8'h00);
  endtask
  // pending sense per initiator and its discard conditions
  task automatic t_pending();
    fire(24'h000001);
    want_pend(8'h00);
    want(3'h0, 5'h13, 8'h80);
    // read mode: only the uncorrectable read error marks the medium
    fire(24'h000030);
    want(3'h0, 5'h13, 8'h90);
    // check condition in the cycle right after the bad select byte
    @(posedge sys_clk);
    ev <= 24'h400000;
    raise_check(3'h2, 4'h0);
    want_pend(8'h04);
    want(3'h2, 5'h1c, 8'h04);
    want(3'h2, 5'h02, 8'h05);
    u_host.send_cmd(3'h1, 8'h08, 1'b0, 8'h00);
    want_pend(8'h04);
    u_host.send_cmd(3'h2, OP_INQUIRY, 1'b0, 8'h00);
    u_host.send_cmd(3'h2, OP_REQUEST_SENSE, 1'b0, 8'h1d);
    want_pend(8'h04);
    u_host.send_cmd(3'h2, 8'h08, 1'b0, 8'h00);
    want_pend(8'h00);
    raise_check(3'h6, 4'h1);
    fire(24'h000002);
    want_pend(8'h00);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    n_fail = 0;
    check_count = 0;
    rstn = 1'b0;
    ev = '0;
    lv = 6'h07;
    sp_req = 32'h0000000a;
    sp_proc = 32'h00000007;
    lep = 24'h000100;
    pos = 24'h000180;
    perr_idx = 8'h03;
    chk_id = 3'h0;
    chk_key = 4'h0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    t_reset();
    t_flags19();
    t_flags20();
    t_flags21();
    t_remain();
    t_counters();
    t_pending();
    results();
  end
  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    results();
  end
endmodule
